// [hdl/lhc_link_flags.sv]
// Link host control flag register with set and clear addresses
// Overview of operation
// - Writes to the set address set flags, writes to the clear address clear them.
// - Bits 31, 29-24, 21-20 and 15-0 always read zero.
// - Bit 30 suppresses byte swapping of outside physical and DMA data accesses.
// - Bit 23 is readable and clearable, not settable, and loads from the EEPROM.
// - Bit 19 permits link-PHY communication when one and forbids it when zero.
// - Bit 18 enables posted writes when one.
// - Bit 17 is cleared by hardware reset and by soft reset.
// - With bit 17 zero the link receives, processes and sends no packets.
// - Setting bit 16 resets link state, flushes FIFOs and restores registers.
// - Soft reset leaves the PCI configuration registers alone.
// - Bit 16 reads one during soft reset and clears itself when done.
`timescale 1ns/100ps
module lhc_link_flags (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // EEPROM load of the PHY programming permission
  input wire logic eepromLoad,
  input wire logic eepromPermit,
  // Link controls
  output logic swapSuppress,
  output logic phyConfigPermit,
  output logic enhancementEnable,
  output logic linkPowerStatus,
  output logic postedWriteOn,
  output logic linkOn,
  output logic linkConnected,
  output logic softResetBusy,
  output logic linkStateReset
);
  lhc_flag_if fl ();

  lhc_apb_slave u_apb (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .fl(fl)
  );

  logic [31:0] flags_r, flags_nxt;
  lhc_pkg::lhc_srst_t srst_r, srst_nxt;
  logic [3:0] srstCnt_r, srstCnt_nxt;
  logic [31:0] setMask;
  logic srstStart;

  // Permission bit cannot be set over the bus
  always_comb begin
    setMask = lhc_pkg::FLAG_MASK;
    setMask[lhc_pkg::BIT_PERMIT] = 1'b0;
  end

  // A set of the soft reset bit starts the sequence
  assign srstStart = fl.setStb & fl.wdata[lhc_pkg::BIT_SRST] & (srst_r == lhc_pkg::ST_IDLE);

  always_comb begin
    flags_nxt = flags_r;
    srst_nxt = srst_r;
    srstCnt_nxt = srstCnt_r;
    if (fl.clrStb) begin
      flags_nxt = flags_nxt & ~(fl.wdata & lhc_pkg::FLAG_MASK);
    end
    if (fl.setStb) begin
      flags_nxt = flags_nxt | (fl.wdata & setMask);
    end
    if (eepromLoad) begin
      flags_nxt[lhc_pkg::BIT_PERMIT] = eepromPermit;
    end
    // Busy bit is hardware owned; software cannot cut a reset short
    flags_nxt[lhc_pkg::BIT_SRST] = flags_r[lhc_pkg::BIT_SRST];
    case (srst_r)
      lhc_pkg::ST_IDLE: begin
        if (srstStart) begin
          srst_nxt = lhc_pkg::ST_RESET;
          srstCnt_nxt = lhc_pkg::SRST_CYCLES;
          // Flags return to reset values; permission keeps its value from before the start, and a load in the same cycle is lost
          flags_nxt = lhc_pkg::FLAG_RESET;
          flags_nxt[lhc_pkg::BIT_PERMIT] = flags_r[lhc_pkg::BIT_PERMIT];
          flags_nxt[lhc_pkg::BIT_LINK] = 1'b0;
          flags_nxt[lhc_pkg::BIT_SRST] = 1'b1;
        end
      end
      lhc_pkg::ST_RESET: begin
        flags_nxt[lhc_pkg::BIT_LINK] = 1'b0;
        if (srstCnt_r == 4'h1) begin
          srst_nxt = lhc_pkg::ST_IDLE;
          srstCnt_nxt = 4'h0;
          flags_nxt[lhc_pkg::BIT_SRST] = 1'b0;
        end else begin
          srstCnt_nxt = srstCnt_r - 4'h1;
        end
      end
      default: begin
        srst_nxt = lhc_pkg::ST_IDLE;
        srstCnt_nxt = 4'h0;
      end
    endcase
    flags_nxt = flags_nxt & lhc_pkg::FLAG_MASK;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= lhc_pkg::FLAG_RESET;
      srst_r <= lhc_pkg::ST_IDLE;
      srstCnt_r <= 4'h0;
    end else begin
      flags_r <= flags_nxt;
      srst_r <= srst_nxt;
      srstCnt_r <= srstCnt_nxt;
    end
  end

  assign fl.flags = flags_r;

  // Output flops; PCI config space is outside this reset
  logic [8:0] outs_r, outs_nxt;
  always_comb begin
    outs_nxt[0] = flags_nxt[lhc_pkg::BIT_SWAP];
    outs_nxt[1] = flags_nxt[lhc_pkg::BIT_PERMIT];
    outs_nxt[2] = flags_nxt[lhc_pkg::BIT_ENH];
    outs_nxt[3] = flags_nxt[lhc_pkg::BIT_LPS];
    outs_nxt[4] = flags_nxt[lhc_pkg::BIT_POSTED];
    outs_nxt[5] = flags_nxt[lhc_pkg::BIT_LINK];
    // Connected only with link on and PHY talk permitted
    outs_nxt[6] = flags_nxt[lhc_pkg::BIT_LINK] & flags_nxt[lhc_pkg::BIT_LPS];
    outs_nxt[7] = flags_nxt[lhc_pkg::BIT_SRST];
    outs_nxt[8] = flags_nxt[lhc_pkg::BIT_SRST];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      outs_r <= 9'h000;
    end else begin
      outs_r <= outs_nxt;
    end
  end

  assign swapSuppress = outs_r[0];
  assign phyConfigPermit = outs_r[1];
  assign enhancementEnable = outs_r[2];
  assign linkPowerStatus = outs_r[3];
  assign postedWriteOn = outs_r[4];
  assign linkOn = outs_r[5];
  assign linkConnected = outs_r[6];
  assign softResetBusy = outs_r[7];
  assign linkStateReset = outs_r[8];

  // Checks
  property p_clear_acts;
    @(posedge clk) disable iff (rst)
      fl.clrStb & ~fl.setStb & fl.wdata[lhc_pkg::BIT_LPS] & ~eepromLoad
      |=> ~flags_r[lhc_pkg::BIT_LPS];
  endproperty
  a_clear_acts: assert property (p_clear_acts) else $error("clear did not clear");

  property p_set_acts;
    @(posedge clk) disable iff (rst)
      fl.setStb & fl.wdata[lhc_pkg::BIT_SWAP] & srst_r == lhc_pkg::ST_IDLE & ~srstStart
      |=> flags_r[lhc_pkg::BIT_SWAP];
  endproperty
  a_set_acts: assert property (p_set_acts) else $error("set did not set");

  property p_zero_keeps;
    @(posedge clk) disable iff (rst)
      ~fl.setStb & ~fl.clrStb & srst_r == lhc_pkg::ST_IDLE |=> $stable(flags_r[19:18]);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag changed without write");

  property p_reserved;
    @(posedge clk) disable iff (rst) (flags_r & ~lhc_pkg::FLAG_MASK) == 32'h00000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_no_set_permit;
    @(posedge clk) disable iff (rst)
      ~flags_r[lhc_pkg::BIT_PERMIT] & ~eepromLoad |=> ~flags_r[lhc_pkg::BIT_PERMIT];
  endproperty
  a_no_set_permit: assert property (p_no_set_permit) else $error("permit was set");

  property p_lps_out;
    @(posedge clk) disable iff (rst)
      linkConnected == (flags_r[lhc_pkg::BIT_LINK] & flags_r[lhc_pkg::BIT_LPS]);
  endproperty
  a_lps_out: assert property (p_lps_out) else $error("connected without permission");

  property p_posted_out;
    @(posedge clk) disable iff (rst) postedWriteOn == flags_r[lhc_pkg::BIT_POSTED];
  endproperty
  a_posted_out: assert property (p_posted_out) else $error("posted output wrong");

  property p_link_cleared;
    @(posedge clk) disable iff (rst) srstStart |=> ~flags_r[lhc_pkg::BIT_LINK] [*8];
  endproperty
  a_link_cleared: assert property (p_link_cleared) else $error("link on in reset");

  property p_srst_len;
    @(posedge clk) disable iff (rst)
      srstStart |=> flags_r[lhc_pkg::BIT_SRST] [*8] ##1 ~flags_r[lhc_pkg::BIT_SRST];
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");

  property p_srst_clears;
    @(posedge clk) disable iff (rst) srstStart |=> flags_r[lhc_pkg::BIT_LPS] == 1'b0;
  endproperty
  a_srst_clears: assert property (p_srst_clears) else $error("flags not reset");

  // Zero bits of a write leave their flags alone
  property p_set_zero_keeps;
    @(posedge clk) disable iff (rst)
      fl.setStb & srst_r == lhc_pkg::ST_IDLE & ~srstStart & ~eepromLoad
      |=> (flags_r & ~$past(fl.wdata)) == ($past(flags_r) & ~$past(fl.wdata));
  endproperty
  a_set_zero_keeps: assert property (p_set_zero_keeps) else $error("set changed bit");

  property p_clr_zero_keeps;
    @(posedge clk) disable iff (rst)
      fl.clrStb & srst_r == lhc_pkg::ST_IDLE & ~eepromLoad
      |=> (flags_r & ~$past(fl.wdata)) == ($past(flags_r) & ~$past(fl.wdata));
  endproperty
  a_clr_zero_keeps: assert property (p_clr_zero_keeps) else $error("clear changed bit");

  // Read data is the flag word seen at the setup edge
  property p_read_flags;
    @(posedge clk) disable iff (rst)
      psel & ~penable & (paddr == lhc_pkg::ADDR_SET | paddr == lhc_pkg::ADDR_CLR)
      |=> prdata == $past(flags_r);
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("read data wrong");

  property p_read_reserved;
    @(posedge clk) disable iff (rst) (prdata & ~lhc_pkg::FLAG_MASK) == 32'h00000000;
  endproperty
  a_read_reserved: assert property (p_read_reserved) else $error("reserved bit read");

  property p_unmapped;
    @(posedge clk) disable iff (rst)
      psel & ~penable & paddr != lhc_pkg::ADDR_SET & paddr != lhc_pkg::ADDR_CLR
      |=> pslverr & prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access wrong");

  property p_swap_out;
    @(posedge clk) disable iff (rst) swapSuppress == flags_r[lhc_pkg::BIT_SWAP];
  endproperty
  a_swap_out: assert property (p_swap_out) else $error("swap output wrong");

  // A load coinciding with a soft reset start is not covered here
  property p_eeprom_load;
    @(posedge clk) disable iff (rst)
      eepromLoad & ~srstStart |=> flags_r[lhc_pkg::BIT_PERMIT] == $past(eepromPermit);
  endproperty
  a_eeprom_load: assert property (p_eeprom_load) else $error("permit not loaded");

  property p_busy_out;
    @(posedge clk) disable iff (rst) softResetBusy == (srst_r == lhc_pkg::ST_RESET);
  endproperty
  a_busy_out: assert property (p_busy_out) else $error("busy output wrong");

  property p_state_reset_out;
    @(posedge clk) disable iff (rst) linkStateReset == (srst_r == lhc_pkg::ST_RESET);
  endproperty
  a_state_reset_out: assert property (p_state_reset_out) else $error("state reset wrong");

  property p_cnt_state;
    @(posedge clk) disable iff (rst) (srst_r == lhc_pkg::ST_RESET) == (srstCnt_r != 4'h0);
  endproperty
  a_cnt_state: assert property (p_cnt_state) else $error("reset counter out of step");

  // A further set of the reset bit must not restart the count
  property p_cnt_step;
    @(posedge clk) disable iff (rst)
      srst_r == lhc_pkg::ST_RESET |=> srstCnt_r == $past(srstCnt_r) - 4'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("reset counter jumped");

  // Hardware reset itself is checked, so no disable here
  property p_hw_reset;
    @(posedge clk) rst |=> ~linkOn & ~flags_r[lhc_pkg::BIT_LINK];
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("link on after reset");

  c_busy_end: cover property (@(posedge clk) disable iff (rst) softResetBusy ##1 ~softResetBusy);
  c_unmapped: cover property (@(posedge clk) disable iff (rst) pslverr);
  c_srst: cover property (@(posedge clk) disable iff (rst) srstStart);
  c_link: cover property (@(posedge clk) disable iff (rst) linkConnected);
  c_eeprom: cover property (@(posedge clk) disable iff (rst) eepromLoad & eepromPermit);
endmodule : lhc_link_flags

// [hdl/lhc_pkg.sv]
// Package of offsets, bit positions and timing for the link control flags
package lhc_pkg;
  localparam logic [7:0] ADDR_SET = 8'h50;
  localparam logic [7:0] ADDR_CLR = 8'h54;
  localparam int BIT_SWAP = 30;
  localparam int BIT_PERMIT = 23;
  localparam int BIT_ENH = 22;
  localparam int BIT_LPS = 19;
  localparam int BIT_POSTED = 18;
  localparam int BIT_LINK = 17;
  localparam int BIT_SRST = 16;
  // Implemented bits; all others read zero
  localparam logic [31:0] FLAG_MASK = 32'h40cf0000;
  localparam logic [31:0] FLAG_RESET = 32'h00000000;
  // Soft reset duration in clock cycles
  localparam logic [3:0] SRST_CYCLES = 4'h8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESET = 2'b01
  } lhc_srst_t;
endpackage : lhc_pkg

// [hdl/lhc_flag_if.sv]
// Interface carrying flag updates between bus slave and flag core
`timescale 1ns/100ps
interface lhc_flag_if;
  logic setStb;
  logic clrStb;
  logic [31:0] wdata;
  logic [31:0] flags;
  modport bus (output setStb, output clrStb, output wdata, input flags);
  modport core (input setStb, input clrStb, input wdata, output flags);
endinterface : lhc_flag_if

// [hdl/lhc_apb_slave.sv]
// APB slave decoding the set and clear addresses
`timescale 1ns/100ps
module lhc_apb_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flag core
  lhc_flag_if.bus fl
);
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic pready_r, pready_nxt;
  logic hitSet, hitClr, access;

  assign access = psel & penable;
  assign hitSet = paddr == lhc_pkg::ADDR_SET;
  assign hitClr = paddr == lhc_pkg::ADDR_CLR;
  // Zero-wait access; write acts at the completing edge
  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign fl.setStb = access & pwrite & hitSet;
  assign fl.clrStb = access & pwrite & hitClr;
  assign fl.wdata = pwdata;

  always_comb begin
    prdata_nxt = 32'h00000000;
    pslverr_nxt = 1'b0;
    // Ready is flopped; low only while reset holds the bus
    pready_nxt = 1'b1;
    if (psel & ~penable) begin
      // Both addresses return the live flags
      if (hitSet | hitClr) begin
        prdata_nxt = fl.flags;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      pready_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      pready_r <= pready_nxt;
    end
  end
endmodule : lhc_apb_slave

// [verification/lhc_link_flags_tb_top.sv]
// Self-checking bench for the link control flag register
`timescale 1ns/100ps
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module lhc_link_flags_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic eepromLoad = 1'b0;
  logic eepromPermit = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, swapSuppress, phyConfigPermit, enhancementEnable, linkPowerStatus;
  logic postedWriteOn, linkOn, linkConnected, softResetBusy, linkStateReset;
  int miscompares = 0;
  int totalChecks = 0;
  int cycles = 0;
  int seed = 86675;
  logic [31:0] model = 32'h00000000;
  logic [31:0] rd;
  logic err;
  logic [8:0] outVec;
  assign outVec = {swapSuppress, phyConfigPermit, enhancementEnable, linkPowerStatus,
    postedWriteOn, linkOn, linkConnected, softResetBusy, linkStateReset};

  lhc_link_flags lhc_link_flags_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eepromLoad(eepromLoad), .eepromPermit(eepromPermit),
    .swapSuppress(swapSuppress), .phyConfigPermit(phyConfigPermit),
    .enhancementEnable(enhancementEnable), .linkPowerStatus(linkPowerStatus),
    .postedWriteOn(postedWriteOn), .linkOn(linkOn), .linkConnected(linkConnected),
    .softResetBusy(softResetBusy), .linkStateReset(linkStateReset));

  always #4 clk = ~clk;

  // Set address cannot raise bit 23; a bit 16 set starts a soft reset
  function automatic logic [31:0] expWrite(logic [31:0] f, logic [7:0] a, logic [31:0] d);
    if (a == lhc_pkg::ADDR_SET && d[16]) return (f & 32'h00800000) | 32'h00010000;
    if (a == lhc_pkg::ADDR_SET) return f | (d & 32'h404e0000);
    if (a == lhc_pkg::ADDR_CLR) return f & ~(d & 32'h40ce0000);
    return f;
  endfunction : expWrite

  function automatic logic [8:0] expOut(logic [31:0] f);
    return {f[30], f[23], f[22], f[19], f[18], f[17], f[17] & f[19], f[16], f[16]};
  endfunction : expOut

  task automatic testDone;
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : testDone

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w) model = expWrite(model, a, d);
    @(posedge clk);
  endtask : apb

  task automatic eeLoad(input logic p);
    eepromLoad <= 1'b1;
    eepromPermit <= p;
    @(posedge clk);
    eepromLoad <= 1'b0;
    @(posedge clk);
    model[23] = p;
  endtask : eeLoad

  task automatic chkRegs;
    apb(1'b0, lhc_pkg::ADDR_SET, 32'h00000000);
    `CHK("set read", model, rd)
    apb(1'b0, lhc_pkg::ADDR_CLR, 32'h00000000);
    `CHK("clear read", model, rd)
    `CHK("outputs", expOut(model), outVec)
  endtask : chkRegs

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      miscompares++;
      testDone;
    end
  end

  initial begin
    logic [31:0] r, d;
    logic [7:0] a;
    int n;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chkRegs;
    eeLoad(1'b1);
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      d = $random(seed) & 32'hfffeffff;
      a = (r[1:0] == 2'b11) ? r[15:8] : (r[0] ? lhc_pkg::ADDR_CLR : lhc_pkg::ADDR_SET);
      if (r[5:4] == 2'b00) eeLoad(r[6]);
      if (!model[23]) d[22] = 1'b0;
      if (a == lhc_pkg::ADDR_SET && !model[17]) d[22] = 1'b0;
      if (model[17]) d[18] = 1'b0;
      apb(1'b1, a, d);
      `CHK("slverr", a != lhc_pkg::ADDR_SET && a != lhc_pkg::ADDR_CLR, err)
      if (err === 1'b1) begin
        apb(1'b0, a, 32'h00000000);
        `CHK("unmapped read", 32'h00000000, rd)
      end
      chkRegs;
    end
    // Hardware reset in mid-run clears every flag, link on included
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    model = 32'h00000000;
    chkRegs;
    eeLoad(1'b0);
    apb(1'b1, lhc_pkg::ADDR_SET, 32'h00800000);
    chkRegs;
    eeLoad(1'b1);
    apb(1'b1, lhc_pkg::ADDR_SET, 32'h400e0000);
    apb(1'b1, lhc_pkg::ADDR_CLR, 32'h00010000);
    chkRegs;
    apb(1'b1, lhc_pkg::ADDR_SET, 32'h00010000);
    `CHK("busy", 1'b1, softResetBusy)
    `CHK("link off", 1'b0, linkOn)
    `CHK("state reset", 1'b1, linkStateReset)
    n = 0;
    while (softResetBusy === 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    `CHK("reset length", int'(lhc_pkg::SRST_CYCLES), n)
    model[16] = 1'b0;
    chkRegs;
    testDone;
  end
endmodule : lhc_link_flags_tb_top
